// file: rtl/psq_top.sv
// Power sequence timing: button hold, rail watch window, restart delay
`timescale 1ns/1ps
module psq_top #(
  parameter int unsigned P_HOLD0 = psq_pkg::HOLD0_CYC,
  parameter int unsigned P_HOLD1 = psq_pkg::HOLD1_CYC,
  parameter int unsigned P_HOLD2 = psq_pkg::HOLD2_CYC,
  parameter int unsigned P_HOLD3 = psq_pkg::HOLD3_CYC,
  parameter int unsigned P_WATCH1 = psq_pkg::WATCH1_CYC,
  parameter int unsigned P_WATCH2 = psq_pkg::WATCH2_CYC,
  parameter int unsigned P_WATCH3 = psq_pkg::WATCH3_CYC,
  parameter int unsigned P_DLY1 = psq_pkg::DLY1_CYC,
  parameter int unsigned P_DLY2 = psq_pkg::DLY2_CYC,
  parameter int unsigned P_DLY3 = psq_pkg::DLY3_CYC,
  parameter int unsigned P_DLY4 = psq_pkg::DLY4_CYC,
  parameter int unsigned P_DLY5 = psq_pkg::DLY5_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire psq_pkg::psq_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic power_button_i,
  input wire logic io_rail_power_good_i,
  input wire logic power_off_done_i,
  output psq_pkg::psq_state_t seq_state_o,
  output logic irq_o
);
  import psq_pkg::*;

  psq_state_t state_ff;
  psq_state_t nxt_state;
  psq_timing_t timing_ff;
  psq_hold_t hold_ff;
  logic [3:0] ists_ff;
  logic [3:0] imsk_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic ack_ff;
  logic [31:0] dat_ff;

  // Bus decode
  wire [9:0] idx = wb_req_i.adr[11:2];
  wire req = wb_req_i.cyc & wb_req_i.stb;
  wire wr_en = req & ack_ff & wb_req_i.we & wb_req_i.sel[0];
  wire wr_timing = wr_en && (idx == IDX_TIMING);
  wire wr_hold = wr_en && (idx == IDX_HOLD);
  wire wr_ists = wr_en && (idx == IDX_ISTS);
  wire wr_imsk = wr_en && (idx == IDX_IMSK);
  wire [7:0] wdat = wb_req_i.dat[7:0];
  wire [7:0] state_word = {3'h0, power_button_i, io_rail_power_good_i, state_ff};
  // Unmapped indices answer with zero
  wire [31:0] rd_word =
    (idx == IDX_TIMING) ? {24'h0, timing_ff} :
    (idx == IDX_HOLD) ? {24'h0, hold_ff} :
    (idx == IDX_STATE) ? {24'h0, state_word} :
    (idx == IDX_ISTS) ? {28'h0, ists_ff} :
    (idx == IDX_IMSK) ? {28'h0, imsk_ff} : 32'h0;

  // Selected limits
  wire [CW-1:0] hold_lim =
    (hold_ff.hold == 2'h0) ? CW'(P_HOLD0) :
    (hold_ff.hold == 2'h1) ? CW'(P_HOLD1) :
    (hold_ff.hold == 2'h2) ? CW'(P_HOLD2) : CW'(P_HOLD3);
  wire [CW-1:0] watch_lim =
    (timing_ff.watch == 2'h1) ? CW'(P_WATCH1) :
    (timing_ff.watch == 2'h2) ? CW'(P_WATCH2) : CW'(P_WATCH3);
  // Codes 6 and 7 fall back to the longest wait
  wire [CW-1:0] dly_lim =
    (timing_ff.delay == 3'h1) ? CW'(P_DLY1) :
    (timing_ff.delay == 3'h2) ? CW'(P_DLY2) :
    (timing_ff.delay == 3'h3) ? CW'(P_DLY3) :
    (timing_ff.delay == 3'h4) ? CW'(P_DLY4) : CW'(P_DLY5);

  wire btn_act = hold_ff.act_high ? power_button_i : ~power_button_i;
  wire hold_done = (cnt_ff == hold_lim - 1'b1);
  wire watch_unlim = (timing_ff.watch == 2'h0);
  wire watch_done = ~watch_unlim && (cnt_ff == watch_lim - 1'b1);
  wire dly_zero = (timing_ff.delay == 3'h0);
  wire dly_done = (cnt_ff == dly_lim - 1'b1);
  psq_state_t off_next;
  assign off_next = dly_zero ? ST_OFF : ST_DELAY;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (btn_act) begin
          nxt_state = hold_ff.long_mode ? ST_HOLD : ST_WATCH;
        end
      end
      ST_HOLD: begin
        if (!btn_act) begin
          nxt_state = ST_OFF;
        end else if (hold_done) begin
          nxt_state = ST_WATCH;
        end
      end
      ST_WATCH: begin
        // Power-good wins over a same-cycle expiry
        if (io_rail_power_good_i) begin
          nxt_state = ST_STANDBY;
        end else if (watch_done) begin
          nxt_state = ST_FAULT;
        end
      end
      ST_STANDBY, ST_FAULT: begin
        if (power_off_done_i) begin
          nxt_state = psq_state_t'(off_next);
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          nxt_state = ST_OFF;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  // Counter restarts on every state change and rests in idle states
  wire timed = (state_ff == ST_HOLD) || (state_ff == ST_WATCH) || (state_ff == ST_DELAY);
  assign nxt_cnt = (timed && nxt_state == state_ff) ? cnt_ff + 1'b1 : '0;

  // Events; a set in the clearing cycle survives
  wire entering = (nxt_state != state_ff);
  wire [3:0] ev;
  assign ev[EV_ACCEPT] = entering && nxt_state == ST_WATCH;
  assign ev[EV_STANDBY] = entering && nxt_state == ST_STANDBY;
  assign ev[EV_FAULT] = entering && nxt_state == ST_FAULT;
  assign ev[EV_READY] = entering && nxt_state == ST_OFF && state_ff != ST_HOLD;
  wire [3:0] nxt_ists = (ists_ff & ~(wr_ists ? wdat[3:0] : 4'h0)) | ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_OFF;
      cnt_ff <= '0;
      ists_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ists_ff <= nxt_ists;
    end
  end

  // Settings take effect on the edge where the master samples ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timing_ff <= psq_timing_t'(TIMING_RST);
      hold_ff <= psq_hold_t'(HOLD_RST);
      imsk_ff <= IMSK_RST;
    end else begin
      if (wr_timing) begin
        timing_ff <= psq_timing_t'({3'h0, wdat[4:0]});
      end
      if (wr_hold) begin
        hold_ff <= psq_hold_t'({4'h0, wdat[3:0]});
      end
      if (wr_imsk) begin
        imsk_ff <= wdat[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) begin
        dat_ff <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign seq_state_o = state_ff;
  assign irq_o = |(ists_ff & imsk_ff);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  hold_release_a: assert property (
    state_ff == ST_HOLD && !btn_act |=> state_ff == ST_OFF)
    else $error("button release did not abort hold");
  hold_accept_a: assert property (
    state_ff == ST_HOLD && btn_act && cnt_ff == hold_lim - 1'b1 |=> state_ff == ST_WATCH)
    else $error("hold period not honoured");
  watch_window_a: assert property (
    state_ff == ST_FAULT && $past(state_ff) == ST_WATCH
      |-> $past(cnt_ff) == watch_lim - 1'b1)
    else $error("fault taken at wrong window length");
  pgood_standby_a: assert property (
    state_ff == ST_WATCH && io_rail_power_good_i |=> state_ff == ST_STANDBY)
    else $error("power-good did not move to standby");
  expiry_fault_a: assert property (
    state_ff == ST_WATCH && !io_rail_power_good_i && !watch_unlim
      && cnt_ff == watch_lim - 1'b1 |=> state_ff == ST_FAULT && ists_ff[EV_FAULT])
    else $error("expiry did not reach fault");
  unlimited_a: assert property (
    state_ff == ST_WATCH && watch_unlim |=> state_ff != ST_FAULT)
    else $error("unlimited window took timeout path");
  restart_wait_a: assert property (
    state_ff == ST_DELAY && cnt_ff != dly_lim - 1'b1 |=> state_ff == ST_DELAY)
    else $error("restart delay cut short");
  no_delay_a: assert property (
    state_ff == ST_STANDBY && power_off_done_i && dly_zero |=> state_ff == ST_OFF)
    else $error("zero delay code still waited");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  off_hold_a: assert property (
    state_ff == ST_OFF && btn_act && hold_ff.long_mode |=> state_ff == ST_HOLD)
    else $error("long press did not start hold");
  short_accept_a: assert property (
    state_ff == ST_OFF && btn_act && !hold_ff.long_mode |=> state_ff == ST_WATCH)
    else $error("short press not accepted at once");
  off_idle_a: assert property (
    state_ff == ST_OFF && !btn_act |=> state_ff == ST_OFF)
    else $error("left idle without a press");
  hold_count_a: assert property (
    state_ff == ST_HOLD && btn_act && !hold_done |=> state_ff == ST_HOLD)
    else $error("hold left before its period");
  hold_len_a: assert property (
    state_ff == ST_WATCH && $past(state_ff) == ST_HOLD |-> $past(cnt_ff) == hold_lim - 1'b1)
    else $error("hold accepted at wrong length");
  accept_event_a: assert property (
    state_ff == ST_WATCH && $past(state_ff) != ST_WATCH |-> ists_ff[EV_ACCEPT])
    else $error("accept event not flagged");
  entry_zero_a: assert property (
    state_ff != $past(state_ff) |-> cnt_ff == '0)
    else $error("counter not restarted on entry");
  cnt_idle_a: assert property (
    state_ff == ST_OFF || state_ff == ST_STANDBY || state_ff == ST_FAULT |-> cnt_ff == '0)
    else $error("counter runs in an idle state");
  watch_wait_a: assert property (
    state_ff == ST_WATCH && !io_rail_power_good_i && !watch_done |=> state_ff == ST_WATCH)
    else $error("watch window left early");
  unlimited_wait_a: assert property (
    state_ff == ST_WATCH && watch_unlim && !io_rail_power_good_i |=> state_ff == ST_WATCH)
    else $error("unlimited window stopped waiting");
  standby_origin_a: assert property (
    state_ff == ST_STANDBY && $past(state_ff) != ST_STANDBY
      |-> $past(state_ff) == ST_WATCH && $past(io_rail_power_good_i))
    else $error("standby reached without power-good");
  standby_event_a: assert property (
    state_ff == ST_STANDBY && $past(state_ff) != ST_STANDBY |-> ists_ff[EV_STANDBY])
    else $error("standby event not flagged");
  standby_stay_a: assert property (
    state_ff == ST_STANDBY && !power_off_done_i |=> state_ff == ST_STANDBY)
    else $error("standby left without power-off");
  fault_origin_a: assert property (
    state_ff == ST_FAULT && $past(state_ff) != ST_FAULT
      |-> $past(state_ff) == ST_WATCH && !$past(io_rail_power_good_i))
    else $error("fault reached from wrong state");
  fault_stay_a: assert property (
    state_ff == ST_FAULT && !power_off_done_i |=> state_ff == ST_FAULT)
    else $error("fault left without power-off");
  fault_delay_a: assert property (
    state_ff == ST_FAULT && power_off_done_i && !dly_zero |=> state_ff == ST_DELAY)
    else $error("fault exit skipped restart delay");
  standby_delay_a: assert property (
    state_ff == ST_STANDBY && power_off_done_i && !dly_zero |=> state_ff == ST_DELAY)
    else $error("standby exit skipped restart delay");
  fault_no_delay_a: assert property (
    state_ff == ST_FAULT && power_off_done_i && dly_zero |=> state_ff == ST_OFF)
    else $error("fault exit waited with zero code");
  delay_origin_a: assert property (
    state_ff == ST_DELAY && $past(state_ff) != ST_DELAY
      |-> $past(power_off_done_i)
      && ($past(state_ff) == ST_STANDBY || $past(state_ff) == ST_FAULT))
    else $error("restart delay entered wrongly");
  delay_end_a: assert property (
    state_ff == ST_DELAY && dly_done |=> state_ff == ST_OFF)
    else $error("restart delay overran");
  delay_len_a: assert property (
    state_ff == ST_OFF && $past(state_ff) == ST_DELAY |-> $past(cnt_ff) == dly_lim - 1'b1)
    else $error("restart delay wrong length");
  ready_event_a: assert property (
    state_ff == ST_OFF && $past(state_ff) != ST_OFF && $past(state_ff) != ST_HOLD
      |-> ists_ff[EV_READY])
    else $error("ready event not flagged");
  event_sets_a: assert property (
    ev != 4'h0 |=> (ists_ff & $past(ev)) == $past(ev))
    else $error("event lost to a clear");
  ists_clear_a: assert property (
    wr_ists && ev == 4'h0 |=> ({4'h0, ists_ff} & $past(wdat)) == 8'h0)
    else $error("status bit not cleared by one");
  ists_sticky_a: assert property (
    !wr_ists |=> (ists_ff & $past(ists_ff)) == $past(ists_ff))
    else $error("status bit dropped without clear");
  ack_latency_a: assert property (
    req && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_idle_a: assert property (
    !req |=> !wb_ack_o)
    else $error("ack without request");
  dat_hold_a: assert property (
    wb_ack_o |=> $stable(wb_dat_o))
    else $error("read data moved after ack");
  write_gate_a: assert property (
    req && !wb_ack_o |=> $stable(timing_ff) && $stable(hold_ff) && $stable(imsk_ff))
    else $error("write landed before ack edge");
  timing_write_a: assert property (
    wr_timing |=> 8'(timing_ff) == ($past(wdat) & 8'h1f))
    else $error("timing write not stored");

  standby_c: cover property (state_ff == ST_WATCH ##1 state_ff == ST_STANDBY);
  fault_c: cover property (state_ff == ST_WATCH ##1 state_ff == ST_FAULT);
  delay_c: cover property (state_ff == ST_DELAY ##1 state_ff == ST_OFF);
  irq_c: cover property (irq_o);
  hold_abort_c: cover property (state_ff == ST_HOLD ##1 state_ff == ST_OFF);
endmodule // psq_top

// file: rtl/psq_pkg.sv
// Constants and types for the power sequence timing block
package psq_pkg;
  localparam int CLK_MHZ = 125;
  localparam int CW = 29;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_TIMING = 10'h071;
  localparam logic [9:0] IDX_HOLD = 10'h072;
  localparam logic [9:0] IDX_STATE = 10'h073;
  localparam logic [9:0] IDX_ISTS = 10'h074;
  localparam logic [9:0] IDX_IMSK = 10'h075;

  localparam logic [7:0] TIMING_RST = 8'h17;
  localparam logic [7:0] HOLD_RST = 8'h0c;
  localparam logic [3:0] IMSK_RST = 4'h0;

  // Times in microseconds
  localparam int HOLD0_US = 1000000;
  localparam int HOLD1_US = 1500000;
  localparam int HOLD2_US = 2000000;
  localparam int HOLD3_US = 3000000;
  localparam int WATCH1_US = 500;
  localparam int WATCH2_US = 1000;
  localparam int WATCH3_US = 2000;
  localparam int DLY1_US = 15000;
  localparam int DLY2_US = 31000;
  localparam int DLY3_US = 63000;
  localparam int DLY4_US = 95000;
  localparam int DLY5_US = 127000;

  localparam int HOLD0_CYC = HOLD0_US * CLK_MHZ;
  localparam int HOLD1_CYC = HOLD1_US * CLK_MHZ;
  localparam int HOLD2_CYC = HOLD2_US * CLK_MHZ;
  localparam int HOLD3_CYC = HOLD3_US * CLK_MHZ;
  localparam int WATCH1_CYC = WATCH1_US * CLK_MHZ;
  localparam int WATCH2_CYC = WATCH2_US * CLK_MHZ;
  localparam int WATCH3_CYC = WATCH3_US * CLK_MHZ;
  localparam int DLY1_CYC = DLY1_US * CLK_MHZ;
  localparam int DLY2_CYC = DLY2_US * CLK_MHZ;
  localparam int DLY3_CYC = DLY3_US * CLK_MHZ;
  localparam int DLY4_CYC = DLY4_US * CLK_MHZ;
  localparam int DLY5_CYC = DLY5_US * CLK_MHZ;

  // Interrupt event bit positions
  localparam int EV_ACCEPT = 0;
  localparam int EV_STANDBY = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_READY = 3;

  typedef struct packed {
    logic [2:0] unused;
    logic [1:0] watch;
    logic [2:0] delay;
  } psq_timing_t;

  typedef struct packed {
    logic [3:0] unused;
    logic act_high;
    logic long_mode;
    logic [1:0] hold;
  } psq_hold_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } psq_wb_req_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_HOLD = 3'h1,
    ST_WATCH = 3'h3,
    ST_STANDBY = 3'h2,
    ST_DELAY = 3'h6,
    ST_FAULT = 3'h7
  } psq_state_t;
endpackage

// file: verification/psq_far_end.sv
// Far side model: push button and rail power-good source
`timescale 1ns/1ps
module psq_far_end (
  input wire logic clk_i,
  input wire logic press_i,
  input wire logic good_i,
  input wire logic done_i,
  output logic button_o = 1'b0,
  output logic pgood_o = 1'b0,
  output logic off_done_o = 1'b0
);
  // Button stays at its active level for as long as the bench holds it
  always @(posedge clk_i) begin
    button_o <= press_i;
    pgood_o <= good_i;
    off_done_o <= done_i;
  end
endmodule // psq_far_end

// file: verification/tb_psq_top.sv
// Self-checking bench for the power sequence timing block
`timescale 1ns/1ps
module tb_psq_top;
  import psq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic press = 1'b0;
  logic good = 1'b0;
  logic done = 1'b0;
  logic button, pgood, off_done, wb_ack_o, irq_o;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  psq_wb_req_t wb_req_i = '0;
  psq_state_t seq_state_o;
  int err_total = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  int n;
  // Short counts keep the run small; expectations follow these values
  localparam int HC0 = 20, HC1 = 30, HC2 = 40, HC3 = 60;
  localparam int WC1 = 5, WC2 = 10, WC3 = 20;
  localparam int DC1 = 3, DC2 = 5, DC3 = 7, DC4 = 9, DC5 = 11;
  int hold_c[4] = '{HC0, HC1, HC2, HC3};
  int watch_c[4] = '{0, WC1, WC2, WC3};
  int dly_c[6] = '{0, DC1, DC2, DC3, DC4, DC5};

  psq_top #(.P_HOLD0(HC0), .P_HOLD1(HC1), .P_HOLD2(HC2), .P_HOLD3(HC3),
    .P_WATCH1(WC1), .P_WATCH2(WC2), .P_WATCH3(WC3),
    .P_DLY1(DC1), .P_DLY2(DC2), .P_DLY3(DC3), .P_DLY4(DC4), .P_DLY5(DC5)) i_psq_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .power_button_i(button), .io_rail_power_good_i(pgood),
    .power_off_done_i(off_done), .seq_state_o(seq_state_o), .irq_o(irq_o));

  psq_far_end i_psq_far_end (.clk_i(clk_i), .press_i(press), .good_i(good),
    .done_i(done), .button_o(button), .pgood_o(pgood), .off_done_o(off_done));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Classic single cycle; waits for ack with no assumed latency
  task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: {idx, 2'b00},
      dat: {24'h0, d}};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req_i <= '0;
  endtask

  // Waits for a state, then counts the cycles it is held
  task automatic dwell(input psq_state_t s, input int exp);
    n = 0;
    while (seq_state_o !== s && n < 500) begin
      @(posedge clk_i);
      #1 n++;
    end
    n = 0;
    while (seq_state_o === s && n < 5000) begin
      @(posedge clk_i);
      #1 n++;
    end
    check(n, exp);
  endtask

  task automatic t_regs;
    bus(1'b0, IDX_TIMING, 8'h00);
    check(rd, 32'h17);
    bus(1'b0, IDX_HOLD, 8'h00);
    check(rd, 32'h0c);
    bus(1'b0, IDX_ISTS, 8'h00);
    check(rd, 32'h0);
    bus(1'b1, IDX_TIMING, 8'hff);
    bus(1'b0, IDX_TIMING, 8'h00);
    check(rd, 32'h1f);
    bus(1'b0, 10'h07f, 8'h00);
    check(rd, 32'h0);
    bus(1'b1, IDX_IMSK, 8'h04);
    bus(1'b0, IDX_IMSK, 8'h00);
    check(rd, 32'h04);
  endtask

  // Short mode with an active-low button, then a long hold cut short by release
  task automatic t_modes;
    bus(1'b1, IDX_ISTS, 8'h0f);
    bus(1'b1, IDX_TIMING, 8'h08);
    bus(1'b1, IDX_HOLD, 8'h00);
    dwell(ST_WATCH, watch_c[1]);
    check(seq_state_o, ST_FAULT);
    check(irq_o, 1'b1);
    bus(1'b0, IDX_STATE, 8'h00);
    check(rd, 32'h07);
    bus(1'b0, IDX_ISTS, 8'h00);
    check(rd, 32'h05);
    bus(1'b1, IDX_ISTS, 8'h0f);
    @(posedge clk_i) begin
      press <= 1'b1;
      done <= 1'b1;
    end
    @(posedge clk_i) done <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check(seq_state_o, ST_OFF);
    bus(1'b1, IDX_HOLD, 8'h04);
    bus(1'b0, IDX_HOLD, 8'h00);
    check(rd, 32'h04);
    @(posedge clk_i) press <= 1'b0;
    repeat (10) @(posedge clk_i);
    press <= 1'b1;
    #1 check(seq_state_o, ST_HOLD);
    repeat (3) @(posedge clk_i);
    #1 check(seq_state_o, ST_OFF);
    bus(1'b0, IDX_ISTS, 8'h00);
    check(rd, 32'h08);
    bus(1'b0, IDX_STATE, 8'h00);
    check(rd, 32'h10);
  endtask

  // One full sequence: hold code, window code and delay code all vary with i
  task automatic t_cycle(input int i);
    bus(1'b1, IDX_HOLD, 8'h0c | 8'(i % 4));
    bus(1'b1, IDX_TIMING, {3'h0, 2'(i % 4), 3'(i)});
    @(posedge clk_i) press <= 1'b1;
    dwell(ST_HOLD, hold_c[i % 4]);
    if (i % 4 == 0) begin
      repeat (100) @(posedge clk_i);
      #1 check(seq_state_o, ST_WATCH);
      @(posedge clk_i) good <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 check(seq_state_o, ST_STANDBY);
      check(irq_o, 1'b0);
    end else begin
      dwell(ST_WATCH, watch_c[i % 4]);
      check(seq_state_o, ST_FAULT);
      check(irq_o, 1'b1);
      bus(1'b1, IDX_ISTS, 8'h0f);
      #1 check(irq_o, 1'b0);
    end
    @(posedge clk_i) begin
      press <= 1'b0;
      good <= 1'b0;
      done <= 1'b1;
    end
    @(posedge clk_i) done <= 1'b0;
    if (i == 0) begin
      repeat (3) @(posedge clk_i);
      #1 check(seq_state_o, ST_OFF);
    end else begin
      dwell(ST_DELAY, dly_c[i]);
      check(seq_state_o, ST_OFF);
    end
  endtask

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Whole run needs under a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      summarize;
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    for (int i = 0; i < 6; i++) begin
      t_cycle(i);
    end
    t_modes;
    summarize;
  end
endmodule // tb_psq_top
